// File: pci_cfg.svh
`ifndef PCI_CFG_SVH
`define PCI_CFG_SVH

// Register byte addresses, ports first, one 16-byte slot per port
`define PCI_ADDR_W          12
`define PCI_PORT_STRIDE     12'h010
`define PCI_RISE_OFS        4'h0
`define PCI_FALL_OFS        4'h4
`define PCI_FLAG_OFS        4'h8
`define PCI_MASTER_ADDR     12'h080
`define PCI_MDIS_ADDR       12'h084
`define PCI_SUMMARY_ADDR    12'h088
`define PCI_ISTAT_ADDR      12'h08C
`define PCI_IEN_ADDR        12'h090
`define PCI_ICLR_ADDR       12'h094

// Field positions
`define PCI_MASTER_BIT      0
`define PCI_MDIS_BIT        0
`define PCI_SUMMARY_BIT     0
`define PCI_EV_CHANGE_BIT   0
`define PCI_EV_WAKE_BIT     1
`define PCI_EV_W            2

// Reset values
`define PCI_EDGE_EN_RST     1'b0
`define PCI_FLAG_RST        1'b0
`define PCI_CTRL_RST        1'b0

// Documented port geometry and the index of the optional fourth port
`define PCI_NUM_PORTS       5
`define PCI_PORT_W          8
`define PCI_FOURTH_PORT_IDX 3

// Synchroniser depth in clock edges before an edge can be seen
`define PCI_SYNC_STAGES     2

`endif

// File: pci_pkg.sv
`include "pci_cfg.svh"

package pci_pkg;

    typedef logic [31:0] pci_word_t;

    typedef logic [`PCI_EV_W-1:0] pci_event_t;

    typedef enum {
        PCI_K_NONE,
        PCI_K_RISE,
        PCI_K_FALL,
        PCI_K_FLAG,
        PCI_K_MASTER,
        PCI_K_MDIS,
        PCI_K_SUMMARY,
        PCI_K_ISTAT,
        PCI_K_IEN,
        PCI_K_ICLR
    } pci_reg_kind_t;

endpackage

// File: pci_pin_sync.sv
`timescale 1ns/1ps
`include "pci_cfg.svh"

module pci_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] rise_pulse,
    output logic      [WIDTH-1:0] fall_pulse
);
    import pci_pkg::*;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] rise_ff;
    logic [WIDTH-1:0] fall_ff;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_async;
            sync_ff <= meta_ff;
        end
    end

    // Edge found by comparing this sample with the one before
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= '0;
            rise_ff <= '0;
            fall_ff <= '0;
        end else begin
            prev_ff <= sync_ff;
            rise_ff <= sync_ff & ~prev_ff;
            fall_ff <= ~sync_ff & prev_ff;
        end
    end

    assign rise_pulse = rise_ff;
    assign fall_pulse = fall_ff;

endmodule // pci_pin_sync

// File: pci_pin_change_interrupt.sv
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "pci_cfg.svh"

// Notes on behaviour
// - Every pin of every port can detect changes, except the fourth port on small variant.
// - Each pin is configured on its own; any combination may request.
// - Change request is raised only while the master enable bit is set.
// - With master enable clear, edges still set flags but no request.
// - Rising edges count only where the pin's rise enable bit is set.
// - Falling edges count only where the pin's fall enable bit is set.
// - Both enables set means edges in either direction count.
// - A counted edge sets the pin's flag, which then stays set.
// - A newly set flag requests an interrupt when master enable is set.
// - Summary flag reads set whenever any pin flag of any port is set.
// - Writing zero to a flag bit clears that flag.
// - An edge during a clearing write leaves the flag set.
// - With master enable set, a detected change wakes the device from sleep.
// - Edges seen in sleep update flags before the first instruction after wake.
// - Module disable bit 0 turns off change detection on all ports.
module pci_pin_change_interrupt #(
    parameter int NUM_PORTS       = `PCI_NUM_PORTS,
    parameter int PORT_W          = `PCI_PORT_W,
    parameter bit HAS_FOURTH_PORT = 1'b1
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`PCI_ADDR_W-1:0]      paddr,
    input  wire pci_pkg::pci_word_t          pwdata,
    input  wire logic [3:0]                  pstrb,
    output pci_pkg::pci_word_t               prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [NUM_PORTS*PORT_W-1:0] port_pins,
    input  wire logic                        sleep_mode,
    output logic                             change_irq_req,
    output logic                             wake_req,
    output logic                             irq
);
    import pci_pkg::*;

    localparam int NB = NUM_PORTS * PORT_W;

    generate
        if (NUM_PORTS < 1 || NUM_PORTS > 8 || PORT_W < 1 || PORT_W > 32) begin : g_bad
            $error("pci_pin_change_interrupt: NUM_PORTS 1..8, PORT_W 1..32");
        end
    endgenerate

    function automatic pci_reg_kind_t reg_kind(input logic [`PCI_ADDR_W-1:0] a);
        pci_reg_kind_t k;
        k = PCI_K_NONE;
        if (int'(a) < NUM_PORTS * int'(`PCI_PORT_STRIDE)) begin
            case (a[3:0])
                `PCI_RISE_OFS: k = PCI_K_RISE;
                `PCI_FALL_OFS: k = PCI_K_FALL;
                `PCI_FLAG_OFS: k = PCI_K_FLAG;
                default:       k = PCI_K_NONE;
            endcase
        end else begin
            case (a)
                `PCI_MASTER_ADDR:  k = PCI_K_MASTER;
                `PCI_MDIS_ADDR:    k = PCI_K_MDIS;
                `PCI_SUMMARY_ADDR: k = PCI_K_SUMMARY;
                `PCI_ISTAT_ADDR:   k = PCI_K_ISTAT;
                `PCI_IEN_ADDR:     k = PCI_K_IEN;
                `PCI_ICLR_ADDR:    k = PCI_K_ICLR;
                default:           k = PCI_K_NONE;
            endcase
        end
        return k;
    endfunction

    logic [NB-1:0]      rise_en_ff;
    logic [NB-1:0]      fall_en_ff;
    logic [NB-1:0]      flag_ff;
    logic [NB-1:0]      nxt_flag;
    logic [NB-1:0]      rise_pulse;
    logic [NB-1:0]      fall_pulse;
    logic [NB-1:0]      hit;
    logic [NB-1:0]      port_ok;
    logic               master_en_ff;
    logic               mdis_ff;
    logic               summary;
    pci_event_t         istat_ff;
    pci_event_t         ien_ff;
    pci_event_t         ev_set;
    pci_word_t          prdata_ff;
    pci_word_t          nxt_prdata;
    logic               pslverr_ff;
    pci_reg_kind_t      kind;
    logic [2:0]         port_idx;
    logic               setup;
    logic               wr;
    logic               wr_lo;
    logic [PORT_W-1:0]  wdata_port;

    assign kind       = reg_kind(paddr);
    assign port_idx   = paddr[6:4];
    assign setup      = psel & ~penable;
    // Narrow registers live in the low byte lanes only
    assign wr_lo      = (PORT_W <= 8) ? pstrb[0] : (&pstrb);
    assign wr         = psel & penable & pwrite & wr_lo;
    assign wdata_port = pwdata[PORT_W-1:0];

    // Pins of an absent fourth port never detect anything
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            if (gp == `PCI_FOURTH_PORT_IDX && !HAS_FOURTH_PORT) begin : g_absent
                assign port_ok[gp*PORT_W +: PORT_W] = '0;
            end else begin : g_present
                assign port_ok[gp*PORT_W +: PORT_W] = '1;
            end
            pci_pin_sync #(
                .WIDTH (PORT_W)
            ) u_sync (
                .pclk       (pclk),
                .presetn    (presetn),
                .pin_async  (port_pins[gp*PORT_W +: PORT_W]),
                .rise_pulse (rise_pulse[gp*PORT_W +: PORT_W]),
                .fall_pulse (fall_pulse[gp*PORT_W +: PORT_W])
            );
        end
    endgenerate

    // Per-pin qualification; both enables give both directions
    assign hit = ((rise_pulse & rise_en_ff)
               | (fall_pulse & fall_en_ff))
               & port_ok & {NB{~mdis_ff}};

    // Edge enables; disable holds them in reset, as it clears the pin flags (master, IEN and ISTAT keep their values)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_en_ff <= {NB{`PCI_EDGE_EN_RST}};
            fall_en_ff <= {NB{`PCI_EDGE_EN_RST}};
        end else if (mdis_ff) begin
            rise_en_ff <= {NB{`PCI_EDGE_EN_RST}};
            fall_en_ff <= {NB{`PCI_EDGE_EN_RST}};
        end else if (wr && kind == PCI_K_RISE) begin
            rise_en_ff[port_idx*PORT_W +: PORT_W] <=
                wdata_port & port_ok[port_idx*PORT_W +: PORT_W];
        end else if (wr && kind == PCI_K_FALL) begin
            fall_en_ff[port_idx*PORT_W +: PORT_W] <=
                wdata_port & port_ok[port_idx*PORT_W +: PORT_W];
        end
    end

    // Written value lands first, then fresh edges are OR-ed over it
    always_comb begin
        nxt_flag = flag_ff;
        if (wr && kind == PCI_K_FLAG) begin
            nxt_flag[port_idx*PORT_W +: PORT_W] =
                wdata_port & port_ok[port_idx*PORT_W +: PORT_W];
        end
        nxt_flag = nxt_flag | hit;
        if (mdis_ff) begin
            nxt_flag = '0;
        end
    end

    // Flags update the cycle after the edge, asleep or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= {NB{`PCI_FLAG_RST}};
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign summary = |flag_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_en_ff <= `PCI_CTRL_RST;
        end else if (wr && kind == PCI_K_MASTER) begin
            master_en_ff <= pwdata[`PCI_MASTER_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdis_ff <= `PCI_CTRL_RST;
        end else if (wr && kind == PCI_K_MDIS) begin
            mdis_ff <= pwdata[`PCI_MDIS_BIT];
        end
    end

    // Flags keep counting with the master switch off
    assign change_irq_req = master_en_ff & summary;
    assign wake_req       = sleep_mode & master_en_ff & summary;

    // Event sources for the sticky status bits
    always_comb begin
        ev_set = '0;
        ev_set[`PCI_EV_CHANGE_BIT] = master_en_ff & (|hit);
        ev_set[`PCI_EV_WAKE_BIT]   = sleep_mode & master_en_ff & (|hit);
    end

    // A new event beats a clear written in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_ff <= '0;
        end else if (wr && kind == PCI_K_ICLR) begin
            istat_ff <= (istat_ff & ~pwdata[`PCI_EV_W-1:0]) | ev_set;
        end else begin
            istat_ff <= istat_ff | ev_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_ff <= '0;
        end else if (wr && kind == PCI_K_IEN) begin
            ien_ff <= pwdata[`PCI_EV_W-1:0];
        end
    end

    assign irq = |(istat_ff & ien_ff);

    // Read mux; while disabled the port registers read as zero
    always_comb begin
        nxt_prdata = '0;
        case (kind)
            PCI_K_RISE:    nxt_prdata[PORT_W-1:0] = rise_en_ff[port_idx*PORT_W +: PORT_W];
            PCI_K_FALL:    nxt_prdata[PORT_W-1:0] = fall_en_ff[port_idx*PORT_W +: PORT_W];
            PCI_K_FLAG:    nxt_prdata[PORT_W-1:0] = flag_ff[port_idx*PORT_W +: PORT_W];
            PCI_K_MASTER:  nxt_prdata[`PCI_MASTER_BIT] = master_en_ff;
            PCI_K_MDIS:    nxt_prdata[`PCI_MDIS_BIT] = mdis_ff;
            PCI_K_SUMMARY: nxt_prdata[`PCI_SUMMARY_BIT] = summary;
            PCI_K_ISTAT:   nxt_prdata[`PCI_EV_W-1:0] = istat_ff;
            PCI_K_IEN:     nxt_prdata[`PCI_EV_W-1:0] = ien_ff;
            default:       nxt_prdata = '0;
        endcase
    end

    // Read data and error are captured in the setup cycle, so no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff  <= pwrite ? '0 : nxt_prdata;
            pslverr_ff <= (kind == PCI_K_NONE);
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = pslverr_ff & psel & penable;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_req_needs_master;
        change_irq_req |-> master_en_ff && (flag_ff != '0);
    endproperty
    a_req_needs_master: assert property (p_req_needs_master)
        else $error("change request raised without master enable or flag");

    property p_flags_without_master;
        (!master_en_ff && hit != '0) |=> (!change_irq_req && ((flag_ff & $past(hit)) != '0));
    endproperty
    a_flags_without_master: assert property (p_flags_without_master)
        else $error("edge with master off did not set flag or raised request");

    property p_no_unqualified_set;
        !$past(wr && kind == PCI_K_FLAG) |->
            ((flag_ff & ~$past(flag_ff) & ~$past(hit)) == '0);
    endproperty
    a_no_unqualified_set: assert property (p_no_unqualified_set)
        else $error("flag set without an enabled edge");

    property p_fall_sets_flag;
        ((fall_pulse & fall_en_ff & port_ok) != '0 && !mdis_ff) |=>
            ((flag_ff & $past(fall_pulse & fall_en_ff & port_ok)) ==
             $past(fall_pulse & fall_en_ff & port_ok));
    endproperty
    a_fall_sets_flag: assert property (p_fall_sets_flag)
        else $error("enabled falling edge did not set its flag");

    property p_rise_sets_flag;
        ((rise_pulse & rise_en_ff & port_ok) != '0 && !mdis_ff) |=>
            ((flag_ff & $past(rise_pulse & rise_en_ff & port_ok)) ==
             $past(rise_pulse & rise_en_ff & port_ok));
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag)
        else $error("enabled rising edge did not set its flag");

    property p_flag_sticky;
        (!$past(wr && kind == PCI_K_FLAG) && !$past(mdis_ff)) |->
            ((~flag_ff & $past(flag_ff)) == '0);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("pin flag dropped without a write or disable");

    property p_event_beats_clear;
        (ev_set != '0) |=> ((istat_ff & $past(ev_set)) == $past(ev_set));
    endproperty
    a_event_beats_clear: assert property (p_event_beats_clear)
        else $error("event status lost against a clear");

    property p_hit_wins;
        (hit != '0 && !mdis_ff) |=> ((flag_ff & $past(hit)) == $past(hit));
    endproperty
    a_hit_wins: assert property (p_hit_wins)
        else $error("detected edge lost against a flag write");

    property p_summary_read;
        (setup && !pwrite && kind == PCI_K_SUMMARY) |=>
            (prdata[`PCI_SUMMARY_BIT] == $past(flag_ff != '0));
    endproperty
    a_summary_read: assert property (p_summary_read)
        else $error("summary flag read disagrees with pin flags");

    property p_write_zero_clears;
        (wr && kind == PCI_K_FLAG && hit == '0 && !mdis_ff) |=>
            (flag_ff[$past(port_idx)*PORT_W +: PORT_W] ==
             ($past(wdata_port) & $past(port_ok[port_idx*PORT_W +: PORT_W])));
    endproperty
    a_write_zero_clears: assert property (p_write_zero_clears)
        else $error("flag write did not take effect");

    property p_wake;
        (sleep_mode && master_en_ff && hit != '0 && !mdis_ff) |=> wake_req || !sleep_mode;
    endproperty
    a_wake: assert property (p_wake)
        else $error("edge in sleep with master enabled gave no wake");

    property p_disable_quiet;
        mdis_ff |=> (flag_ff == '0) && !change_irq_req && (hit == '0);
    endproperty
    a_disable_quiet: assert property (p_disable_quiet)
        else $error("disabled module still holds flags or edges");

    property p_absent_port;
        (hit & ~port_ok) == '0 && (rise_en_ff & ~port_ok) == '0;
    endproperty
    a_absent_port: assert property (p_absent_port)
        else $error("absent port pin detected an edge");

endmodule // pci_pin_change_interrupt

// File: pci_pin_model.sv
`timescale 1ns/1ps

module pci_pin_model #(
    parameter int W = 40
) (
    input  wire logic         pclk,
    input  wire logic [W-1:0] level,
    input  wire logic [3:0]   hold,
    output logic      [W-1:0] port_pins
);
    logic [3:0] wait_ff;

    initial begin
        port_pins = '0;
        wait_ff   = 4'h0;
    end

    // Pins move just after an edge and then rest for hold cycles, so every level lasts at
    // least one full clock; a slow source is modelled by a larger hold
    always @(posedge pclk) begin
        if (wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (port_pins != level) begin
            port_pins <= level;
            wait_ff   <= hold;
        end
    end
endmodule // pci_pin_model

// File: tb.sv
`timescale 1ns/1ps
`include "pci_cfg.svh"

module tb;
    import pci_pkg::*;
    typedef struct packed {logic err; pci_word_t data;} pci_exp_t;
    logic                   pclk, presetn, psel, penable, pwrite, sleep_mode, dis;
    logic                   pready, pslverr, change_irq_req, wake_req, irq;
    logic [`PCI_ADDR_W-1:0] paddr;
    pci_word_t              pwdata, prdata;
    logic [3:0]             pstrb, hold;
    logic [39:0]            level, port_pins, ren, fen, flg;
    logic [7:0]             m, f;
    pci_exp_t               exp_q[$];
    pci_exp_t               cur;
    int                     errors, n_compared, seed;

    pci_pin_change_interrupt uut (
        .pclk           (pclk),
        .presetn        (presetn),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .pstrb          (pstrb),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .port_pins      (port_pins),
        .sleep_mode     (sleep_mode),
        .change_irq_req (change_irq_req),
        .wake_req       (wake_req),
        .irq            (irq)
    );

    pci_pin_model pins (
        .pclk      (pclk),
        .level     (level),
        .hold      (hold),
        .port_pins (port_pins)
    );

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    function automatic pci_word_t b(input logic x);
        return {31'h0, x};
    endfunction

    function automatic logic [11:0] fa(input int p, input logic [3:0] o);
        return `PCI_PORT_STRIDE * 12'(p) + {8'h00, o};
    endfunction

    task automatic chk(input pci_word_t got, input pci_word_t want);
        n_compared++;
        if (got !== want) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic end_sim;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Read expectation is queued; the monitor checks it at the access edge
    task automatic apb(input logic w, input logic [11:0] a, input pci_word_t d, input logic e);
        exp_q.push_back('{e, d});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input pci_word_t d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input pci_word_t d);
        apb(1'b0, a, d, 1'b0);
    endtask

    // Shadow flags follow enabled edges; disable blocks them
    task automatic drive(input int p, input logic [7:0] x);
        logic [39:0] nv;
        nv = level;
        nv[p*8+:8] = x;
        if (!dis) flg = flg | (~level & nv & ren) | (level & ~nv & fen);
        level <= nv;
        repeat (10) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            cur = exp_q.pop_front();
            chk(b(pslverr), b(cur.err));
            if (!pwrite) chk(prdata, cur.data);
        end
    end

    initial begin
        #200000;
        errors++;
        end_sim();
    end

    initial begin
        seed = 3244;
        errors = 0;
        n_compared = 0;
        {psel, penable, pwrite, sleep_mode, dis} = '0;
        {paddr, pwdata, level, ren, fen, flg} = '0;
        pstrb = 4'hF;
        hold = 4'h0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            for (int o = 0; o < 12; o += 4) rd(fa(p, o[3:0]), 32'h0);
        end
        rd(`PCI_SUMMARY_ADDR, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0, 1'b1);
        hold <= 4'h2;
        for (int p = 0; p < 5; p++) begin
            m = 8'($random(seed)) | 8'h01;
            f = 8'($random(seed)) | 8'h01;
            ren[p*8+:8] = m;
            fen[p*8+:8] = f;
            wr(fa(p, `PCI_RISE_OFS), {24'h0, m});
            wr(fa(p, `PCI_FALL_OFS), {24'h0, f});
            rd(fa(p, `PCI_RISE_OFS), {24'h0, m});
            rd(fa(p, `PCI_FALL_OFS), {24'h0, f});
            repeat (3) drive(p, 8'($random(seed)));
            rd(fa(p, `PCI_FLAG_OFS), {24'h0, flg[p*8+:8]});
            @(negedge pclk);
            chk(b(change_irq_req), 32'h0);
        end
        hold <= 4'h0;
        drive(0, level[7:0] ^ 8'h01);
        rd(`PCI_SUMMARY_ADDR, 32'h1);
        wr(`PCI_MASTER_ADDR, 32'h1);
        @(negedge pclk);
        chk(b(change_irq_req), 32'h1);
        wr(`PCI_ICLR_ADDR, 32'h3);
        wr(`PCI_IEN_ADDR, 32'h1);
        drive(0, level[7:0] ^ 8'h01);
        rd(`PCI_ISTAT_ADDR, 32'h1);
        @(negedge pclk);
        chk(b(irq), 32'h1);
        wr(`PCI_IEN_ADDR, 32'h0);
        @(negedge pclk);
        chk(b(irq), 32'h0);
        @(posedge pclk);
        sleep_mode <= 1'b1;
        drive(0, level[7:0] ^ 8'h01);
        @(negedge pclk);
        chk(b(wake_req), 32'h1);
        rd(fa(0, `PCI_FLAG_OFS), {24'h0, flg[7:0]});
        rd(`PCI_ISTAT_ADDR, 32'h3);
        sleep_mode <= 1'b0;
        // Software writes zero to the whole flag register, clearing every bit of the port
        for (int p = 0; p < 5; p++) begin
            rd(fa(p, `PCI_FLAG_OFS), {24'h0, flg[p*8+:8]});
            wr(fa(p, `PCI_FLAG_OFS), {24'h0, flg[p*8+:8] & ~flg[p*8+:8]});
            flg[p*8+:8] = 8'h00;
            rd(fa(p, `PCI_FLAG_OFS), 32'h0);
        end
        rd(`PCI_SUMMARY_ADDR, 32'h0);
        @(negedge pclk);
        chk(b(change_irq_req), 32'h0);
        // Clearing write lands on the edge that sets the flag
        level[0] <= ~level[0];
        repeat (2) @(posedge pclk);
        wr(fa(0, `PCI_FLAG_OFS), 32'h0);
        repeat (4) @(posedge pclk);
        rd(fa(0, `PCI_FLAG_OFS), 32'h1);
        wr(`PCI_MDIS_ADDR, 32'h1);
        dis = 1'b1;
        flg = '0;
        rd(fa(0, `PCI_FLAG_OFS), 32'h0);
        wr(fa(0, `PCI_RISE_OFS), 32'hFF);
        rd(fa(0, `PCI_RISE_OFS), 32'h0);
        drive(0, ~level[7:0]);
        rd(`PCI_SUMMARY_ADDR, 32'h0);
        wr(`PCI_MDIS_ADDR, 32'h0);
        dis = 1'b0;
        rd(fa(0, `PCI_FALL_OFS), 32'h0);
        rd(fa(0, `PCI_FLAG_OFS), 32'h0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(`PCI_MASTER_ADDR, 32'h0);
        rd(fa(1, `PCI_RISE_OFS), 32'h0);
        // A write without the low byte lane must leave the register alone
        pstrb <= 4'hE;
        wr(fa(1, `PCI_RISE_OFS), 32'hFF);
        pstrb <= 4'hF;
        rd(fa(1, `PCI_RISE_OFS), 32'h0);
        end_sim();
    end
endmodule // tb
